//--- verilog/wwkm_top.sv
// Windowed watchdog with kick qualifier, action outputs and registers.
//
// Contract
// R1: A kick must arrive inside the allowed window or the watchdog acts.
// R2: The kick comes from one of bus lines 24 to 28, chosen by a strap.
// R3: Only one kick source is fitted on the board at a time.
// R4: The kicker drives its line high for at least 100 us per kick.
// R5: The kicker kicks every 1.25 s so that no timeout occurs.
// R6: On expiry the output drives bus reset, power-off, or both as set.
// R7: The supervisor micro can force the watchdog action by command.
// R8: The bus reset line is active low.
// R9: The power-off request is active high.
// R10: Kick pulses shorter than the minimum high time are ignored.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "wwkm_regs.svh"
module wwkm_top
   import wwkm_pkg::*;
#(
   parameter int TIMEOUT_CYC  = `WWKM_TIMEOUT_CYC,
   parameter int WIN_OPEN_CYC = `WWKM_WIN_OPEN_CYC,
   parameter int ACTION_CYC   = `WWKM_ACTION_CYC,
   parameter int KICK_MIN_CYC = `WWKM_KICK_MIN_CYC
)
(
   // Clock and reset.
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   // Bus kick lines 24 to 28 and selection strap.
   input  wire logic [4:0]  KICK_LINES_I,
   input  wire logic [2:0]  KICK_SEL_I,
   // Supervisor micro register port.
   input  wire logic [3:0]  ADDR_I,
   input  wire logic [7:0]  WDATA_I,
   input  wire logic        WR_I,
   input  wire logic        RD_I,
   output logic [7:0]       RDATA_O,
   // Bus action outputs.
   output logic             BUS_RESET_N_O,
   output logic             BUS_RESET_OE_O,
   output logic             POWER_OFF_O,
   output logic             IRQ_O
);
   logic              kick;
   wwkm_kick_ev_t     ev;
   wwkm_state_t       st_q;
   wwkm_state_t       st_d;
   logic [31:0]       cnt_q;
   logic [31:0]       cnt_d;
   logic [7:0]        ctrl_q;
   logic [7:0]        ctrl_d;
   logic [3:0]        stat_q;
   logic [3:0]        stat_d;
   logic [3:0]        en_q;
   logic [3:0]        en_d;
   logic [7:0]        rdata_q;
   logic [7:0]        rdata_d;
   logic              rst_n_q;
   logic              rst_n_d;
   logic              off_q;
   logic              off_d;
   logic              oe_q;
   logic              oe_d;
   logic              irq_q;
   logic              irq_d;
   logic              force_cmd;
   logic              expire;
   logic [3:0]        ev_set;

   wwkm_kick_qual #(
      .MIN_CYC (KICK_MIN_CYC)
   ) u_qual (
      .clk_i   (CLK_I),
      .srst_i  (SRST_I),
      .lines_i (KICK_LINES_I),
      .sel_i   (KICK_SEL_I),
      .kick_o  (kick)
   );

   // Watchdog window and action sequencer.
   always_comb
   begin
      st_d      = st_q;
      cnt_d     = cnt_q + 32'h1;
      force_cmd = WR_I && (ADDR_I == `WWKM_ADDR_CTRL) &&
                  WDATA_I[`WWKM_CTRL_FORCE];
      ev.kick   = 1'b0;
      ev.early  = 1'b0;
      expire    = 1'b0;
      case (st_q)
         WWKM_WATCH:
         begin
            if (force_cmd) // R7
            begin
               st_d  = WWKM_ACT;
               cnt_d = 32'h0;
            end
            else if (kick)
            begin
               // A kick before the window opens is a failure too.
               if (cnt_q < 32'(WIN_OPEN_CYC)) // R1
               begin
                  ev.early = 1'b1;
                  st_d     = WWKM_ACT;
               end
               else
               begin
                  ev.kick = 1'b1;
               end
               cnt_d = 32'h0;
            end
            else if (cnt_q >= 32'(TIMEOUT_CYC - 1)) // R1
            begin
               expire = 1'b1;
               st_d   = WWKM_ACT;
               cnt_d  = 32'h0;
            end
         end
         WWKM_ACT:
         begin
            if (cnt_q >= 32'(ACTION_CYC - 1))
            begin
               st_d  = WWKM_WATCH;
               cnt_d = 32'h0;
            end
         end
         default:
         begin
            st_d  = WWKM_WATCH;
            cnt_d = 32'h0;
         end
      endcase
      // Outputs follow the next state so they leave flip-flops directly.
      // The enables come from the next control value, so a force that also
      // rewrites them never acts for one cycle on the stale setting.
      rst_n_d = !((st_d == WWKM_ACT) && ctrl_d[`WWKM_CTRL_RST_EN]); // R6 R8
      oe_d    = (st_d == WWKM_ACT) && ctrl_d[`WWKM_CTRL_RST_EN]; // R6 R8
      off_d   = (st_d == WWKM_ACT) && ctrl_d[`WWKM_CTRL_OFF_EN]; // R6 R9
   end

   // Register file with sticky status; a new event wins over a clear.
   always_comb
   begin
      ev_set                  = 4'h0;
      ev_set[`WWKM_EV_TIMEOUT] = expire;
      ev_set[`WWKM_EV_EARLY]   = ev.early;
      ev_set[`WWKM_EV_FORCE]   = force_cmd && (st_q == WWKM_WATCH);
      ev_set[`WWKM_EV_KICK]    = ev.kick;
      ctrl_d  = ctrl_q;
      en_d    = en_q;
      stat_d  = stat_q;
      rdata_d = 8'h00;
      if (WR_I && (ADDR_I == `WWKM_ADDR_CTRL))
      begin
         ctrl_d = {5'h00, 1'b0, WDATA_I[1:0]};
      end
      else if (WR_I && (ADDR_I == `WWKM_ADDR_CLEAR))
      begin
         stat_d = stat_q & ~WDATA_I[3:0];
      end
      else if (WR_I && (ADDR_I == `WWKM_ADDR_ENABLE))
      begin
         en_d = WDATA_I[3:0];
      end
      stat_d = stat_d | ev_set;
      if (RD_I && (ADDR_I == `WWKM_ADDR_CTRL))
      begin
         rdata_d = ctrl_q;
      end
      else if (RD_I && (ADDR_I == `WWKM_ADDR_STATUS))
      begin
         rdata_d = {3'h0, st_q == WWKM_ACT, stat_q};
      end
      else if (RD_I && (ADDR_I == `WWKM_ADDR_ENABLE))
      begin
         rdata_d = {4'h0, en_q};
      end
      irq_d = |(stat_d & en_d);
   end

   // Sequencer state and the action outputs.
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         st_q    <= WWKM_WATCH;
         cnt_q   <= 32'h0;
         rst_n_q <= 1'b1;
         oe_q    <= 1'b0;
         off_q   <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         rst_n_q <= rst_n_d;
         oe_q    <= oe_d;
         off_q   <= off_d;
      end
   end

   // Register file state.
   always_ff @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         ctrl_q  <= `WWKM_CTRL_RESET;
         stat_q  <= 4'h0;
         en_q    <= 4'h0;
         rdata_q <= 8'h00;
         irq_q   <= 1'b0;
      end
      else
      begin
         ctrl_q  <= ctrl_d;
         stat_q  <= stat_d;
         en_q    <= en_d;
         rdata_q <= rdata_d;
         irq_q   <= irq_d;
      end
   end

   // The reset line is open drain: it is only ever pulled low.
   assign BUS_RESET_N_O  = rst_n_q;
   assign BUS_RESET_OE_O = oe_q;
   assign POWER_OFF_O    = off_q;
   assign RDATA_O        = rdata_q;
   assign IRQ_O          = irq_q;
endmodule : wwkm_top
`default_nettype wire

//--- verilog/wwkm_regs.svh
// Offsets, field positions, reset values and timing counts of the watchdog.
`ifndef WWKM_REGS_SVH
`define WWKM_REGS_SVH
`define WWKM_CLK_HZ          200000000
`define WWKM_KICK_MIN_US     100
`define WWKM_KICK_MIN_CYC    ((`WWKM_KICK_MIN_US * (`WWKM_CLK_HZ / 1000000)))
`define WWKM_TIMEOUT_MS      1250
`define WWKM_TIMEOUT_CYC     ((`WWKM_TIMEOUT_MS * (`WWKM_CLK_HZ / 1000)))
`define WWKM_WIN_OPEN_CYC    0
`define WWKM_ACTION_CYC      1000
`define WWKM_ADDR_CTRL       4'h0
`define WWKM_ADDR_STATUS     4'h4
`define WWKM_ADDR_CLEAR      4'h8
`define WWKM_ADDR_ENABLE     4'hC
`define WWKM_CTRL_RST_EN     0
`define WWKM_CTRL_OFF_EN     1
`define WWKM_CTRL_FORCE      2
`define WWKM_CTRL_RESET      8'h01
`define WWKM_EV_TIMEOUT      0
`define WWKM_EV_EARLY        1
`define WWKM_EV_FORCE        2
`define WWKM_EV_KICK         3
`define WWKM_EV_W            4
`endif

//--- verilog/wwkm_pkg.sv
// Types shared by the watchdog files.
package wwkm_pkg;
   typedef struct packed {
      logic       early;
      logic       kick;
   } wwkm_kick_ev_t;
   typedef enum logic [1:0] {
      WWKM_WATCH  = 2'b00,
      WWKM_ACT    = 2'b01
   } wwkm_state_t;
endpackage : wwkm_pkg

//--- verilog/wwkm_kick_qual.sv
// Synchroniser, bus line selector and pulse width qualifier for the kick.
`timescale 1ns/1ps
`default_nettype none
`include "wwkm_regs.svh"
module wwkm_kick_qual
   import wwkm_pkg::*;
#(
   parameter int MIN_CYC = `WWKM_KICK_MIN_CYC
)
(
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Bus lines and strap.
   input  wire logic [4:0]  lines_i,
   input  wire logic [2:0]  sel_i,
   // Qualified kick.
   output logic             kick_o
);
   logic [4:0]  s1_q;
   logic [4:0]  s2_q;
   logic [4:0]  s1_d;
   logic [4:0]  s2_d;
   logic [2:0]  selm_q;
   logic [2:0]  selm_d;
   logic [2:0]  sel_q;
   logic [2:0]  sel_d;
   logic        line;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic        kick_q;
   logic        kick_d;

   always_comb
   begin
      s1_d   = lines_i;
      s2_d   = s1_q;
      // The strap is a pin as well, so it passes two flip-flops too.
      selm_d = sel_i;
      sel_d  = selm_q;
      line   = (sel_q < 3'h5) ? s2_q[sel_q] : 1'b0; // R2
      cnt_d  = cnt_q;
      kick_d = 1'b0;
      if (!line)
      begin
         cnt_d = 16'h0000;
      end
      else if (cnt_q != 16'(MIN_CYC))
      begin
         cnt_d = cnt_q + 16'h0001;
         // A kick counts once, the moment the high time reaches the minimum.
         kick_d = (cnt_q == 16'(MIN_CYC - 1)); // R10
      end
   end

   always_ff @(posedge clk_i)
   begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      selm_q <= selm_d;
      if (srst_i)
      begin
         sel_q  <= 3'h3;
         cnt_q  <= 16'h0000;
         kick_q <= 1'b0;
      end
      else
      begin
         sel_q  <= sel_d;
         cnt_q  <= cnt_d;
         kick_q <= kick_d;
      end
   end

   assign kick_o = kick_q;
endmodule : wwkm_kick_qual
`default_nettype wire

//--- test/wwkm_kick_host.sv
// Host model that pulses one stack bus kick line.
`timescale 1ns/1ps
`default_nettype none
module wwkm_kick_host
(
   // Clock and request.
   input  wire logic       clk_i,
   input  wire logic       go_i,
   input  wire logic [2:0] sel_i,
   input  wire logic [7:0] width_i,
   // Kick lines 24 to 28.
   output logic [4:0]      lines_o
);
   logic [7:0] left_q = 8'h00;
   always_ff @(posedge clk_i)
      left_q <= go_i ? width_i : left_q - {7'h0, left_q != 8'h00};
   // Lines rest low, so a missing pulse never reads as a kick.
   assign lines_o = (left_q != 8'h00) ? 5'h01 << sel_i : 5'h00;
endmodule : wwkm_kick_host
`default_nettype wire

//--- test/wwkm_top_assertions.sv
// Port checker for the windowed watchdog.
`timescale 1ns/1ps
`default_nettype none
module wwkm_chk
(
   // Clock, reset and register port.
   input wire logic       CLK_I,
   input wire logic       SRST_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic       WR_I,
   input wire logic       RD_I,
   input wire logic [7:0] RDATA_O,
   // Action outputs.
   input wire logic       BUS_RESET_N_O,
   input wire logic       BUS_RESET_OE_O,
   input wire logic       POWER_OFF_O,
   input wire logic       IRQ_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   // Only a force from idle is judged, as forces while acting are ignored.
   // Idle outputs only mean idle state while some action is enabled.
   logic [1:0] ctl_q;
   always_ff @(posedge CLK_I)
      if (SRST_I) ctl_q <= 2'h1;
      else if (WR_I && ADDR_I == 4'h0) ctl_q <= WDATA_I[1:0];
   wire logic go = WR_I && ADDR_I == 4'h0 && WDATA_I[2] && BUS_RESET_N_O
                   && !POWER_OFF_O && (|ctl_q);
   oe_follow_a: assert property (BUS_RESET_OE_O == !BUS_RESET_N_O)
      else $error("drain enable wrong");
   rd_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
      else $error("read data outside read");
   unmap_rd_a: assert property (RD_I && (ADDR_I[1:0] != 2'h0 ||
      ADDR_I == 4'h8) |=> RDATA_O == 8'h00) else $error("bad read data");
   stat_rd_a: assert property (RD_I && ADDR_I == 4'h4 |=> RDATA_O[7:5] ==
      3'h0) else $error("status spare bits");
   force_rst_a: assert property (go && WDATA_I[0] |-> ##2 !BUS_RESET_N_O)
      else $error("force missed reset");
   force_off_a: assert property (go && WDATA_I[1] |-> ##2 POWER_OFF_O)
      else $error("force missed power off");
   rst_hold_a: assert property ($fell(BUS_RESET_N_O) |-> !BUS_RESET_N_O[*8])
      else $error("reset too short");
   irq_mask_a: assert property (WR_I && ADDR_I == 4'hC && WDATA_I == 8'h00
      |-> ##3 !IRQ_O) else $error("masked irq high");
   cover property (go);
   cover property ($fell(BUS_RESET_N_O));
   cover property ($rose(IRQ_O));
endmodule : wwkm_chk
bind wwkm_top wwkm_chk i_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .BUS_RESET_N_O(BUS_RESET_N_O),
   .BUS_RESET_OE_O(BUS_RESET_OE_O), .POWER_OFF_O(POWER_OFF_O),
   .IRQ_O(IRQ_O));
`default_nettype wire

//--- test/tb_wwkm_top.sv
// Self-checking bench for the windowed watchdog.
`timescale 1ns/1ps
`default_nettype none
module tb_wwkm_top;
   logic        CLK_I = 1'h0, SRST_I = 1'h1, WR_I = 1'h0, RD_I = 1'h0;
   logic        go = 1'h0, BUS_RESET_N_O, BUS_RESET_OE_O, POWER_OFF_O, IRQ_O;
   logic [4:0]  lines;
   logic [2:0]  KICK_SEL_I = 3'h3, hsel = 3'h3;
   logic [3:0]  ADDR_I = 4'h0;
   logic [7:0]  WDATA_I = 8'h00, w = 8'h08, RDATA_O;
   int          n_fail = 0, num_checks = 0, cyc = 0, i;
   logic [20:0] rows [8] = '{{1'h0, 4'h0, 8'h00, 8'h01},
      {1'h0, 4'h4, 8'h00, 8'h00}, {1'h1, 4'h4, 8'hFF, 8'h00},
      {1'h0, 4'h4, 8'h00, 8'h00}, {1'h1, 4'hC, 8'h0F, 8'h00},
      {1'h0, 4'hC, 8'h00, 8'h0F}, {1'h0, 4'h8, 8'h00, 8'h00},
      {1'h0, 4'h6, 8'h00, 8'h00}};
   wire logic [7:0] outs = {4'h0, BUS_RESET_OE_O, POWER_OFF_O, IRQ_O,
                            BUS_RESET_N_O};
   wwkm_kick_host i_host (.clk_i(CLK_I), .go_i(go), .sel_i(hsel),
      .width_i(w), .lines_o(lines));
   wwkm_top #(.TIMEOUT_CYC(200), .WIN_OPEN_CYC(30), .ACTION_CYC(10),
      .KICK_MIN_CYC(5)) i_dut (.CLK_I(CLK_I), .SRST_I(SRST_I),
      .KICK_LINES_I(lines), .KICK_SEL_I(KICK_SEL_I), .ADDR_I(ADDR_I),
      .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
      .BUS_RESET_N_O(BUS_RESET_N_O), .BUS_RESET_OE_O(BUS_RESET_OE_O),
      .POWER_OFF_O(POWER_OFF_O), .IRQ_O(IRQ_O));
   task automatic chk(input string s, input logic [7:0] g, e);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      {WR_I, ADDR_I, WDATA_I} <= {1'h1, a, d};
      @(posedge CLK_I);
      WR_I <= 1'h0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
      @(posedge CLK_I);
      {RD_I, ADDR_I} <= {1'h1, a};
      @(posedge CLK_I);
      RD_I <= 1'h0;
      #1 chk("rdata", RDATA_O & m, e);
   endtask : rd
   task automatic kick(input logic [7:0] n);
      @(posedge CLK_I);
      {go, w} <= {1'h1, n};
      @(posedge CLK_I);
      go <= 1'h0;
   endtask : kick
   task automatic wfor(input logic v, input int n);
      for (int k = 0; k < n && BUS_RESET_N_O !== v; k++)
         @(posedge CLK_I) #1;
   endtask : wfor
   task complete_run;
      if (n_fail == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : complete_run
   initial
   begin
      forever #2.5 CLK_I = ~CLK_I;
   end
   always @(posedge CLK_I)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         complete_run;
      end
   end
   initial
   begin
      repeat (10) @(posedge CLK_I);
      SRST_I <= 1'h0;
      #1 chk("outs", outs, 8'h01);
      for (i = 0; i < 8; i++)
         if (rows[i][20]) wr(rows[i][19:16], rows[i][15:8]);
         else rd(rows[i][19:16], rows[i][7:0], 8'hFF);
      repeat (20) @(posedge CLK_I);
      for (i = 0; i < 5; i++)
      begin
         {KICK_SEL_I, hsel} <= {3'(i), 3'(i)};
         kick(8'h08);
         repeat (90) @(posedge CLK_I);
         #1 chk("outs", outs, 8'h03);
      end
      rd(4'h4, 8'h08, 8'h08);
      kick(8'h08);
      repeat (12) @(posedge CLK_I);
      kick(8'h02);
      repeat (4) @(posedge CLK_I);
      hsel <= 3'h0;
      kick(8'h08);
      repeat (170) @(posedge CLK_I);
      #1 chk("outs", outs, 8'h03);
      wfor(1'h0, 40);
      repeat (2) @(posedge CLK_I);
      #1 chk("outs", outs, 8'h0A);
      rd(4'h4, 8'h01, 8'h01);
      wr(4'h8, 8'h0F);
      wfor(1'h1, 20);
      rd(4'h4, 8'h00, 8'h0F);
      wr(4'h0, 8'h07);
      @(posedge CLK_I);
      #1 chk("outs", outs, 8'h0E);
      rd(4'h4, 8'h04, 8'h04);
      wr(4'hC, 8'h00);
      repeat (3) @(posedge CLK_I);
      #1 chk("irq", {7'h0, IRQ_O}, 8'h00);
      wfor(1'h1, 20);
      chk("outs", outs, 8'h01);
      hsel <= 3'h4;
      kick(8'h08);
      wfor(1'h0, 30);
      #1 chk("outs", outs, 8'h0C);
      rd(4'h4, 8'h02, 8'h02);
      @(posedge CLK_I);
      SRST_I <= 1'h1;
      repeat (2) @(posedge CLK_I);
      SRST_I <= 1'h0;
      #1 chk("outs", outs, 8'h01);
      rd(4'h4, 8'h00, 8'hFF);
      rd(4'h0, 8'h01, 8'hFF);
      complete_run;
   end
endmodule : tb_wwkm_top
`default_nettype wire
